/* File: include/uv_eprom_host_defines.vh */
// constants for the uv eprom host-side controller
`ifndef UV_EPROM_HOST_DEFINES_VH
`define UV_EPROM_HOST_DEFINES_VH
`define ADDR_W 14
`define DATA_W 8
`define WORD_COUNT 16384
`define ERASED_WORD 8'hff
`define PULSE_TIME_NS 100000
`define CLK_PERIOD_NS 10
`define PULSE_CYCLES (`PULSE_TIME_NS / `CLK_PERIOD_NS)
`define SETTLE_CYCLES 4
`define MAX_PULSES 25
`define PARITY_BIT 7
`define CMD_READ 3'h0
`define CMD_PROGRAM 3'h1
`define CMD_IDENT 3'h2
`define CMD_FINAL_VERIFY 3'h3
`define CMD_STANDBY 3'h4
`endif

/* File: hw/pulse_timer.v */
// down-counter timing program pulses and settle intervals
`default_nettype none
module pulse_timer #(
  parameter WIDTH = 14
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [WIDTH-1:0] load,
  output reg done
);
  reg [WIDTH-1:0] count;
  reg running;
  always @(posedge clk) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= load;
        running <= 1'b1;
      end else if (running) begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/uv_eprom_host.v */
// host controller driving the pins of a 16k x 8 uv eprom
// Functional notes
// - program mode needs programming voltage, chip select and strobe low.
// - programmer presents the whole eight-bit word on the data lines.
// - 100 us pulses, verify after each, repeat until match or limit.
// - pulse loop at 6.25 V supply; final whole-array verify at 5.25 V.
// - parallel parts share inputs; high chip select inhibits programming.
// - verify with output enable, chip select low, strobe high, vpp on.
// - identification mode by high voltage on address line nine.
// - in identification all address lines but nine and zero are held low.
// - memory drives only with chip select and output enable low.
// - chip select is the device select; output enable is the read strobe.
`default_nettype none
`include "uv_eprom_host_defines.vh"
module uv_eprom_host #(
  parameter PULSE_CYCLES = `PULSE_CYCLES,
  parameter MAX_PULSES = `MAX_PULSES,
  parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [`ADDR_W-1:0] cmd_addr,
  input wire [`DATA_W-1:0] cmd_data,
  output reg cmd_ready,
  output reg rsp_valid,
  output reg [`DATA_W-1:0] rsp_data,
  output reg rsp_fail,
  output reg rsp_parity_ok,
  output reg [7:0] rsp_pulses,
  output reg [`ADDR_W-1:0] address_lines,
  output reg address_line_nine_high,
  output reg [`DATA_W-1:0] data_lines_out,
  output reg data_lines_oe,
  input wire [`DATA_W-1:0] data_lines_in,
  output reg chip_select_n,
  output reg output_enable_n,
  output reg program_strobe_n,
  output reg vpp_program_on,
  output reg vcc_program_level,
  output reg vcc_verify_level
);
  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE = 7'h01;
  localparam S_SETUP = 7'h02;
  localparam S_PULSE = 7'h04;
  localparam S_RECOVER = 7'h08;
  localparam S_SAMPLE = 7'h10;
  localparam S_DONE = 7'h20;
  localparam S_PARK = 7'h40;
  localparam TW = 14;
  // timer adds two cycles of latency, so load short to keep the strobe low exactly PULSE_CYCLES
  localparam integer PULSE_LOAD = PULSE_CYCLES - 2;

  reg [6:0] state;
  reg [2:0] op;
  reg [7:0] pulses;
  reg tstart;
  reg [TW-1:0] tload;
  wire tdone;

  pulse_timer #(.WIDTH(TW)) timer (
    .clk(clk),
    .rst(rst),
    .start(tstart),
    .load(tload),
    .done(tdone)
  );

  function odd_parity;
    input [7:0] b;
    begin
      odd_parity = ^b;
    end
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      op <= `CMD_STANDBY;
      pulses <= 8'h00;
      tstart <= 1'b0;
      tload <= {TW{1'b0}};
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_fail <= 1'b0;
      rsp_parity_ok <= 1'b0;
      rsp_pulses <= 8'h00;
      address_lines <= {`ADDR_W{1'b0}};
      address_line_nine_high <= 1'b0;
      data_lines_out <= 8'h00;
      data_lines_oe <= 1'b0;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      program_strobe_n <= 1'b1;
      vpp_program_on <= 1'b0;
      vcc_program_level <= 1'b0;
      vcc_verify_level <= 1'b0;
    end else begin
      tstart <= 1'b0;
      rsp_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            pulses <= 8'h00;
            // identification forces other address lines low
            if (cmd_op == `CMD_IDENT) begin
              // bit zero picks maker or device byte
              address_lines <= {{(`ADDR_W-1){1'b0}}, cmd_addr[0]};
            end else begin
              address_lines <= cmd_addr;
            end
            data_lines_out <= cmd_data;
            if (cmd_op == `CMD_STANDBY) begin
              state <= S_DONE;
            end else begin
              chip_select_n <= 1'b0;
              address_line_nine_high <= (cmd_op == `CMD_IDENT);
              vcc_program_level <= (cmd_op == `CMD_PROGRAM);
              vcc_verify_level <= (cmd_op == `CMD_FINAL_VERIFY);
              vpp_program_on <= (cmd_op == `CMD_PROGRAM);
              tload <= SETTLE_CYCLES[TW-1:0];
              tstart <= 1'b1;
              state <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          if (tdone) begin
            if (op == `CMD_PROGRAM) begin
              // host drives data from strobe start until the recovery settle ends
              data_lines_oe <= 1'b1;
              output_enable_n <= 1'b1;
              // strobe low with vpp and chip select
              program_strobe_n <= 1'b0;
              tload <= PULSE_LOAD[TW-1:0];
              tstart <= 1'b1;
              state <= S_PULSE;
            end else begin
              output_enable_n <= 1'b0;
              tload <= SETTLE_CYCLES[TW-1:0];
              tstart <= 1'b1;
              state <= S_SAMPLE;
            end
          end
        end
        S_PULSE: begin
          if (tdone) begin
            // end of one 100 us pulse
            program_strobe_n <= 1'b1;
            pulses <= pulses + 8'h01;
            tload <= SETTLE_CYCLES[TW-1:0];
            tstart <= 1'b1;
            state <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          if (tdone) begin
            data_lines_oe <= 1'b0;
            // verify with strobe high, vpp still on
            output_enable_n <= 1'b0;
            tload <= SETTLE_CYCLES[TW-1:0];
            tstart <= 1'b1;
            state <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          if (tdone) begin
            rsp_data <= data_lines_in;
            if (op == `CMD_PROGRAM) begin
              if (data_lines_in == data_lines_out || pulses >= MAX_PULSES[7:0]) begin
                rsp_fail <= (data_lines_in != data_lines_out);
                state <= S_PARK;
              end else begin
                output_enable_n <= 1'b1;
                data_lines_oe <= 1'b1;
                program_strobe_n <= 1'b0;
                tload <= PULSE_LOAD[TW-1:0];
                tstart <= 1'b1;
                state <= S_PULSE;
              end
            end else begin
              // a one wanted where a zero is stored is unreachable
              rsp_fail <= (op == `CMD_FINAL_VERIFY) && (data_lines_in != cmd_data);
              state <= S_PARK;
            end
            // odd parity check on every sampled byte, id bytes included
            rsp_parity_ok <= odd_parity(data_lines_in);
          end
        end
        S_PARK: begin
          // back to standby, memory releases the lines
          output_enable_n <= 1'b1;
          chip_select_n <= 1'b1;
          program_strobe_n <= 1'b1;
          vpp_program_on <= 1'b0;
          vcc_program_level <= 1'b0;
          vcc_verify_level <= 1'b0;
          address_line_nine_high <= 1'b0;
          data_lines_oe <= 1'b0;
          state <= S_DONE;
        end
        S_DONE: begin
          rsp_valid <= 1'b1;
          rsp_pulses <= pulses;
          if (op == `CMD_STANDBY) begin
            rsp_fail <= 1'b0;
            chip_select_n <= 1'b1;
          end
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/uv_eprom_host_checker.sv */
// pin-level assertions for the uv eprom host controller
`default_nettype none
module uv_eprom_host_checker #(parameter PULSE_CYCLES = 20) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_parity_ok,
  input wire logic [13:0] address_lines,
  input wire logic address_line_nine_high,
  input wire logic data_lines_oe,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic program_strobe_n,
  input wire logic vpp_program_on,
  input wire logic vcc_program_level,
  input wire logic vcc_verify_level
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt;
  always_ff @(posedge clk) low_cnt <= program_strobe_n ? 0 : low_cnt + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // pin relations
  // ****************
  strobe_mode_a: assert property (!program_strobe_n |-> !chip_select_n && vpp_program_on)
    else $error("strobe low outside program mode");
  pulse_level_a: assert property (!program_strobe_n |-> vcc_program_level && data_lines_oe)
    else $error("pulse without drive or level");
  pulse_len_a: assert property ($rose(program_strobe_n) |-> low_cnt == PULSE_CYCLES)
    else $error("pulse length wrong");
  no_fight_a: assert property (data_lines_oe |-> output_enable_n)
    else $error("host drives while memory enabled");
  verify_pins_a: assert property ($fell(output_enable_n) && vpp_program_on |-> program_strobe_n)
    else $error("verify with strobe low");
  read_select_a: assert property (!output_enable_n |-> !chip_select_n)
    else $error("read strobe without select");
  ident_addr_a: assert property (address_line_nine_high |-> address_lines[13:10] == 0 && address_lines[8:1] == 0)
    else $error("ident address lines not low");
  final_level_a: assert property (vcc_verify_level |-> !vcc_program_level && program_strobe_n)
    else $error("final verify level wrong");
  parity_flag_a: assert property (rsp_valid |-> rsp_parity_ok == ^rsp_data)
    else $error("parity flag wrong");
  answer_bound_a: assert property (cmd_valid && cmd_ready |-> ##[2:400] rsp_valid)
    else $error("no answer");
  cover property (!program_strobe_n);
  cover property (address_line_nine_high && !output_enable_n);
  cover property (vcc_verify_level && !output_enable_n);
endmodule
bind uv_eprom_host uv_eprom_host_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_uv_eprom_host_checker (.clk, .rst,
  .cmd_valid, .cmd_ready, .rsp_valid, .rsp_data, .rsp_parity_ok, .address_lines, .address_line_nine_high,
  .data_lines_oe, .chip_select_n, .output_enable_n, .program_strobe_n, .vpp_program_on, .vcc_program_level,
  .vcc_verify_level);
`default_nettype wire

/* File: testbench/eprom_model.sv */
// behavioural model of the 16k x 8 uv eprom pins
`default_nettype none
module eprom_model #(parameter logic [7:0] MAKER = 8'h4c, DEVICE = 8'hb3) (
  input wire logic clk,
  input wire logic [13:0] a,
  input wire logic nine,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic pgm_n,
  input wire logic vpp,
  input wire logic host_oe,
  input wire logic [7:0] host_q,
  output logic [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ident values are arbitrary, both of odd parity
  logic [7:0] mem [0:16383];
  logic [7:0] last = 8'h00;
  logic [7:0] word;
  logic drive;
  initial for (int i = 0; i < 16384; i++) mem[i] = 8'hff;
  assign word = nine ? (a[0] ? DEVICE : MAKER) : mem[a];
  assign drive = !cs_n && !oe_n;
  // released bus toggles so stale data never matches
  assign bus = host_oe ? host_q : (drive ? word : ~last);
  always @(posedge clk) begin
    last <= bus;
    if (vpp && !cs_n && !pgm_n && host_oe) mem[a] <= mem[a] & host_q;
  end
endmodule
`default_nettype wire

/* File: testbench/uv_eprom_host_tb.sv */
// self-checking bench for the uv eprom host controller
`default_nettype none
`define CHK(x, e) begin comparisons++; if ((x) !== (e)) begin mismatches++; $display("mismatch %0t %h %h", $time, x, e); end end
module uv_eprom_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam MP = 3;
  logic clk = 0, rst = 1, cmd_valid = 0;
  logic [2:0] cmd_op = 0;
  logic [13:0] cmd_addr = 0;
  logic [7:0] cmd_data = 0;
  wire cmd_ready, rsp_valid, rsp_fail, rsp_parity_ok, nine, oe, cs_n, oe_n, pgm_n, vpp, vcc_p, vcc_v;
  wire [7:0] rsp_data, rsp_pulses, q_out, bus;
  wire [13:0] a;
  int mismatches = 0, comparisons = 0, cycles = 0;
  uv_eprom_host #(.PULSE_CYCLES(20), .MAX_PULSES(MP), .SETTLE_CYCLES(4)) i_uv_eprom_host (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail), .rsp_parity_ok(rsp_parity_ok),
    .rsp_pulses(rsp_pulses), .address_lines(a), .address_line_nine_high(nine), .data_lines_out(q_out),
    .data_lines_oe(oe), .data_lines_in(bus), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .program_strobe_n(pgm_n), .vpp_program_on(vpp), .vcc_program_level(vcc_p), .vcc_verify_level(vcc_v));
  eprom_model #(.MAKER(8'h4c), .DEVICE(8'hb3)) i_eprom_model (.clk(clk), .a(a), .nine(nine), .cs_n(cs_n),
    .oe_n(oe_n), .pgm_n(pgm_n), .vpp(vpp), .host_oe(oe), .host_q(q_out), .bus(bus));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cycles == 20000) begin mismatches++; summarize(); end
  task summarize;
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one command, held until taken, answer awaited under a bound
  task automatic run(input logic [2:0] op, input logic [13:0] ad, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    #1 cmd_op = op;
    cmd_addr = ad;
    cmd_data = d;
    cmd_valid = 1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 0;
    // look just after the edge, while the one-cycle answer still stands
    do begin
      @(posedge clk);
      #1 n++;
    end while (rsp_valid !== 1'b1 && n < 500);
    `CHK(rsp_valid, 1'b1)
  endtask
  task t_erased;
    run(0, 14'h3fff, 0); `CHK(rsp_data, 8'hff)
  endtask
  task t_program;
    run(1, 14'h1234, 8'h5a); `CHK(rsp_fail, 1'b0)
    `CHK(rsp_pulses, 8'h01)
    run(0, 14'h1234, 0); `CHK(rsp_data, 8'h5a)
    `CHK(rsp_parity_ok, 1'b0)
    run(3, 14'h1234, 8'h5a); `CHK(rsp_fail, 1'b0)
    run(3, 14'h1234, 8'h5b); `CHK(rsp_fail, 1'b1)
    // zeros cannot return to one, so every pulse is spent
    run(1, 14'h1234, 8'hff); `CHK(rsp_fail, 1'b1)
    `CHK(rsp_pulses, 8'(MP))
  endtask
  task t_ident;
    run(2, 14'h3ffe, 0); `CHK(rsp_data, 8'h4c)
    `CHK(rsp_parity_ok, 1'b1)
    run(2, 14'h0001, 0); `CHK(rsp_data, 8'hb3)
    `CHK(rsp_parity_ok, 1'b1)
    run(0, 0, 0); `CHK(rsp_data, 8'hff)
  endtask
  task t_standby;
    run(4, 0, 0); `CHK(cs_n, 1'b1)
    `CHK(i_eprom_model.drive, 1'b0)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    t_erased();
    t_program();
    t_ident();
    t_standby();
    summarize();
  end
endmodule
`default_nettype wire
